/* design/etc_chan.v */
`timescale 1ns/1ps
`include "etc_defs.vh"

module etc_chan (
  input wire clk_sys,
  input wire rst_n,
  input wire [15:0] cmp_reg,
  input wire load,
  input wire [15:0] cnt,
  input wire [15:0] cnt_nxt,
  input wire evt_step,
  input wire pwm_on,
  input wire pwm_step,
  input wire trig_hit,
  input wire restart,
  output reg match_irq,
  output reg pwm_out
);

reg [15:0] buf_r;
reg irq_nxt;
reg out_nxt;

always @* begin
  irq_nxt = 1'b0;
  out_nxt = pwm_out;
  // R9: event mode match once per period
  // R10: unreachable buffer never matches
  if (evt_step && cnt == buf_r) begin
    irq_nxt = 1'b1;
  end
  // R20: irq in the matching cycle
  if (pwm_step && cnt_nxt == buf_r) begin
    irq_nxt = 1'b1;
  end
  if (!pwm_on) begin
    out_nxt = 1'b0;
  // R16: trigger forces output high
  end else if (trig_hit) begin
    out_nxt = 1'b1;
  // R17: active for buffer count cycles
  end else if (pwm_step && cnt_nxt == buf_r) begin
    out_nxt = 1'b0;
  end else if (restart) begin
    out_nxt = 1'b1;
  end
end

always @(posedge clk_sys or negedge rst_n) begin
  if (!rst_n) begin
    buf_r <= `ETC_CCR_RST;
    match_irq <= 1'b0;
    pwm_out <= 1'b0;
  end else begin
    if (load) begin
      buf_r <= cmp_reg;
    end
    match_irq <= irq_nxt;
    pwm_out <= out_nxt;
  end
end

endmodule // etc_chan

/* design/etc_defs.vh */
`ifndef ETC_DEFS_VH
`define ETC_DEFS_VH
// Register byte offsets
`define ETC_OFF_CTRL 6'h00
`define ETC_OFF_SWTRIG 6'h04
`define ETC_OFF_PERIOD 6'h08
`define ETC_OFF_CH1 6'h0C
`define ETC_OFF_CH2 6'h10
`define ETC_OFF_CH3 6'h14
`define ETC_OFF_COUNT 6'h18
`define ETC_OFF_STATUS 6'h1C
// Control field positions
`define ETC_CTRL_MODE_HI 2
`define ETC_CTRL_MODE_LO 0
`define ETC_CTRL_RUN 3
`define ETC_CTRL_EVT_HI 5
`define ETC_CTRL_EVT_LO 4
`define ETC_CTRL_TRG_HI 7
`define ETC_CTRL_TRG_LO 6
`define ETC_CTRL_RST 8'h00
`define ETC_SWTRIG_BIT 0
`define ETC_STAT_WAIT 0
`define ETC_STAT_RUN 1
// Modes
`define ETC_MODE_EVENT 3'h1
`define ETC_MODE_PWM 3'h2
// Valid edge selections
`define ETC_EDGE_NONE 2'h0
`define ETC_EDGE_RISE 2'h1
`define ETC_EDGE_FALL 2'h2
`define ETC_EDGE_BOTH 2'h3
// Counter values
`define ETC_CNT_ZERO 16'h0000
`define ETC_CNT_ONE 16'h0001
`define ETC_CNT_MAX 16'hFFFF
`define ETC_CCR_RST 16'hFFFF
// Read data padding
`define ETC_PAD16 16'h0000
`define ETC_PAD24 24'h000000
`define ETC_PAD30 30'h00000000
`endif

/* design/etc_sync_edge.v */
`timescale 1ns/1ps
`include "etc_defs.vh"

module etc_sync_edge (
  input wire clk_sys,
  input wire rst_n,
  input wire pin,
  input wire [1:0] edge_sel,
  output reg edge_pulse
);

reg s1_r;
reg s2_r;
reg s3_r;
reg lvl_r;
reg pulse_nxt;
wire agree;
wire rise;
wire fall;

// Level accepted only while the two late stages agree
assign agree = (s2_r == s3_r);
assign rise = agree & s3_r & ~lvl_r;
assign fall = agree & ~s3_r & lvl_r;

// R23: configured edge
always @* begin
  case (edge_sel)
    `ETC_EDGE_RISE: pulse_nxt = rise;
    `ETC_EDGE_FALL: pulse_nxt = fall;
    `ETC_EDGE_BOTH: pulse_nxt = rise | fall;
    default: pulse_nxt = 1'b0;
  endcase
end

// R23: three-stage sync
always @(posedge clk_sys or negedge rst_n) begin
  if (!rst_n) begin
    s1_r <= 1'b0;
    s2_r <= 1'b0;
    s3_r <= 1'b0;
    lvl_r <= 1'b0;
    edge_pulse <= 1'b0;
  end else begin
    s1_r <= pin;
    s2_r <= s1_r;
    s3_r <= s2_r;
    if (agree) begin
      lvl_r <= s3_r;
    end
    edge_pulse <= pulse_nxt;
  end
end

endmodule // etc_sync_edge

/* design/etc_timer.v */
// Our own choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`include "etc_defs.vh"

// Summary of operation
// R1: mode field 001 selects event counting, only on this timer.
// R2: mode field 010 selects triggered PWM, only on this timer.
// R3: event mode run start clears counter FFFF to 0, loads period buffer.
// R4: event mode counts valid event input edges, not clock cycles.
// R5: counter equal to period buffer clears to 0 and pulses period irq.
// R6: first period irq after N edges, later ones after N+1.
// R7: period FFFF wraps to zero with irq, no overflow flag.
// R8: event mode period write reaches buffer at once; overshoot wraps.
// R9: event mode channel buffers load; smaller value matches once per period.
// R10: channel value above period never raises its irq.
// R11: software keeps outputs unused in event mode.
// R12: software never writes 0000 to compare registers in event mode.
// R13: software sets unused channel compares to FFFF and masks them.
// R14: software uses interval mode when outputs needed with events.
// R15: PWM run start waits; trigger clears counter, starts, drives outputs.
// R16: trigger while running restarts counter, inverts toggle, drives channels high.
// R17: channel output active for its compare value within period+1 cycles.
// R18: toggle output has half period of period value plus one.
// R19: PWM period irq on the step after match, with counter clear.
// R20: PWM channel irq in the cycle counter equals its buffer.
// R21: PWM buffers reload only at the start trigger and on period match clearing the counter.
// R22: trigger is trigger input valid edge or software trigger write.
// R23: event and trigger inputs synchronised and edge-selected first.
module etc_timer (
  input wire clk_sys,
  input wire rstn,
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire event_count_input,
  input wire external_trigger_input,
  output reg period_toggle_out,
  output wire [2:0] channel_pwm_out,
  output reg period_match_irq,
  output wire [2:0] channel_match_irq
);

localparam ST_IDLE = 2'h0;
localparam ST_WAIT = 2'h1;
localparam ST_RUN = 2'h2;

function [15:0] etc_inc;
  input [15:0] v;
  begin
    etc_inc = v + `ETC_CNT_ONE;
  end
endfunction

function [31:0] etc_pad16;
  input [15:0] v;
  begin
    etc_pad16 = {`ETC_PAD16, v};
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Reset release

reg rst_meta_r;
reg rst_n_r;

always @(posedge clk_sys or negedge rstn) begin
  if (!rstn) begin
    rst_meta_r <= 1'b0;
    rst_n_r <= 1'b0;
  end else begin
    rst_meta_r <= 1'b1;
    rst_n_r <= rst_meta_r;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Declarations

reg [7:0] ctrl_r;
reg [15:0] per_r;
reg [15:0] ch_cmp_r [0:2];
reg swtrig_r;
reg [15:0] cnt_r;
reg [15:0] cnt_nxt;
reg [1:0] st_r;
reg [1:0] st_nxt;
reg [15:0] buf0_r;
reg first_r;
reg start_load;
reg trig_hit;
reg pmatch;
reg evt_step;
reg pwm_step;
reg [31:0] rd_nxt;
wire [2:0] mode;
wire run_en;
wire is_evt;
wire is_pwm;
wire evt_edge;
wire trg_edge;
wire trig;
wire req;
wire acc;
wire wr_acc;
wire wr_per;
wire [2:0] wr_ch;
wire pwm_on;
wire restart;
wire [2:0] ch_load;

assign mode = ctrl_r[`ETC_CTRL_MODE_HI:`ETC_CTRL_MODE_LO];
assign run_en = ctrl_r[`ETC_CTRL_RUN];
// R1: event counting select
assign is_evt = (mode == `ETC_MODE_EVENT);
// R2: triggered PWM select
assign is_pwm = (mode == `ETC_MODE_PWM);

////////////////////////////////////////////////////////////////////////////////
// Input synchronisers

etc_sync_edge u_evt_sync (
  .clk_sys(clk_sys),
  .rst_n(rst_n_r),
  .pin(event_count_input),
  .edge_sel(ctrl_r[`ETC_CTRL_EVT_HI:`ETC_CTRL_EVT_LO]),
  .edge_pulse(evt_edge)
);

etc_sync_edge u_trg_sync (
  .clk_sys(clk_sys),
  .rst_n(rst_n_r),
  .pin(external_trigger_input),
  .edge_sel(ctrl_r[`ETC_CTRL_TRG_HI:`ETC_CTRL_TRG_LO]),
  .edge_pulse(trg_edge)
);

// R22: hardware or software trigger
assign trig = trg_edge | swtrig_r;

////////////////////////////////////////////////////////////////////////////////
// Register bus

// One wait state on every access keeps read data a plain flop
assign req = avs_read | avs_write;
assign acc = req & ~avs_waitrequest;
assign wr_acc = acc & avs_write;
assign wr_per = wr_acc & (avs_address == `ETC_OFF_PERIOD);
assign wr_ch[0] = wr_acc & (avs_address == `ETC_OFF_CH1);
assign wr_ch[1] = wr_acc & (avs_address == `ETC_OFF_CH2);
assign wr_ch[2] = wr_acc & (avs_address == `ETC_OFF_CH3);

always @* begin
  case (avs_address)
    `ETC_OFF_CTRL: rd_nxt = {`ETC_PAD24, ctrl_r};
    `ETC_OFF_PERIOD: rd_nxt = etc_pad16(per_r);
    `ETC_OFF_CH1: rd_nxt = etc_pad16(ch_cmp_r[0]);
    `ETC_OFF_CH2: rd_nxt = etc_pad16(ch_cmp_r[1]);
    `ETC_OFF_CH3: rd_nxt = etc_pad16(ch_cmp_r[2]);
    `ETC_OFF_COUNT: rd_nxt = etc_pad16(cnt_r);
    `ETC_OFF_STATUS: rd_nxt = {`ETC_PAD30, st_r == ST_RUN, st_r == ST_WAIT};
    default: rd_nxt = {`ETC_PAD16, `ETC_PAD16};
  endcase
end

always @(posedge clk_sys or negedge rst_n_r) begin
  if (!rst_n_r) begin
    avs_waitrequest <= 1'b1;
    avs_readdata <= {`ETC_PAD16, `ETC_PAD16};
  end else begin
    if (acc) begin
      avs_waitrequest <= 1'b1;
    end else if (req) begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= rd_nxt;
    end
  end
end

always @(posedge clk_sys or negedge rst_n_r) begin
  if (!rst_n_r) begin
    ctrl_r <= `ETC_CTRL_RST;
    per_r <= `ETC_CCR_RST;
    ch_cmp_r[0] <= `ETC_CCR_RST;
    ch_cmp_r[1] <= `ETC_CCR_RST;
    ch_cmp_r[2] <= `ETC_CCR_RST;
    swtrig_r <= 1'b0;
  end else begin
    // R22: software trigger is a one-cycle strobe
    swtrig_r <= wr_acc & (avs_address == `ETC_OFF_SWTRIG)
      & avs_writedata[`ETC_SWTRIG_BIT];
    if (wr_acc && avs_address == `ETC_OFF_CTRL) begin
      ctrl_r <= avs_writedata[7:0];
    end
    if (wr_per) begin
      per_r <= avs_writedata[15:0];
    end
    if (wr_ch[0]) begin
      ch_cmp_r[0] <= avs_writedata[15:0];
    end
    if (wr_ch[1]) begin
      ch_cmp_r[1] <= avs_writedata[15:0];
    end
    if (wr_ch[2]) begin
      ch_cmp_r[2] <= avs_writedata[15:0];
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Counter state machine

always @* begin
  st_nxt = st_r;
  cnt_nxt = cnt_r;
  start_load = 1'b0;
  trig_hit = 1'b0;
  pmatch = 1'b0;
  evt_step = 1'b0;
  pwm_step = 1'b0;
  if (!run_en) begin
    st_nxt = ST_IDLE;
    cnt_nxt = `ETC_CNT_MAX;
  end else begin
    case (st_r)
      ST_IDLE: begin
        // R3: start clears counter, loads buffers
        if (is_evt) begin
          st_nxt = ST_RUN;
          cnt_nxt = `ETC_CNT_ZERO;
          start_load = 1'b1;
        // R15: PWM start waits for a trigger
        end else if (is_pwm) begin
          st_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!is_pwm) begin
          st_nxt = ST_IDLE;
        // R15: trigger starts counting from zero
        end else if (trig) begin
          st_nxt = ST_RUN;
          cnt_nxt = `ETC_CNT_ZERO;
          start_load = 1'b1;
          trig_hit = 1'b1;
        end
      end
      ST_RUN: begin
        if (is_evt) begin
          // R4: step only on event edges
          if (evt_edge) begin
            evt_step = 1'b1;
            // R6: first period one edge shorter
            // R5: match clears and interrupts
            // R7: FFFF match wraps without overflow flag
            if (first_r ? (etc_inc(cnt_r) == buf0_r) : (cnt_r == buf0_r)) begin
              cnt_nxt = `ETC_CNT_ZERO;
              pmatch = 1'b1;
            end else begin
              cnt_nxt = etc_inc(cnt_r);
            end
          end
        end else if (is_pwm) begin
          // R16: retrigger restarts, beats a match
          if (trig) begin
            cnt_nxt = `ETC_CNT_ZERO;
            trig_hit = 1'b1;
          end else begin
            pwm_step = 1'b1;
            // R19: clear on step after match
            if (cnt_r == buf0_r) begin
              cnt_nxt = `ETC_CNT_ZERO;
              pmatch = 1'b1;
            end else begin
              cnt_nxt = etc_inc(cnt_r);
            end
          end
        end else begin
          st_nxt = ST_IDLE;
          cnt_nxt = `ETC_CNT_MAX;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
        cnt_nxt = `ETC_CNT_MAX;
      end
    endcase
  end
end

assign pwm_on = is_pwm & run_en & (st_r != ST_IDLE);
assign restart = pwm_step & pmatch;

always @(posedge clk_sys or negedge rst_n_r) begin
  if (!rst_n_r) begin
    st_r <= ST_IDLE;
    cnt_r <= `ETC_CNT_MAX;
    buf0_r <= `ETC_CCR_RST;
    first_r <= 1'b0;
    period_match_irq <= 1'b0;
    period_toggle_out <= 1'b0;
  end else begin
    st_r <= st_nxt;
    cnt_r <= cnt_nxt;
    if (start_load) begin
      first_r <= is_evt;
    end else if (pmatch) begin
      first_r <= 1'b0;
    end
    // R8: event mode write reaches buffer at once
    // R21: PWM reload only at start trigger and period clear
    if (start_load || (wr_per && is_evt && st_r == ST_RUN) || restart) begin
      buf0_r <= wr_per ? avs_writedata[15:0] : per_r;
    end
    // R5: period irq pulse
    period_match_irq <= pmatch;
    // R18: toggle on every period clear
    // R16: toggle on every trigger
    if (!pwm_on) begin
      period_toggle_out <= 1'b0;
    end else if (trig_hit || restart) begin
      period_toggle_out <= ~period_toggle_out;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Channels

// Writes in event mode pass straight to the buffer; PWM waits for the clear
// R9: event mode channel buffers follow writes
assign ch_load = {3{start_load | restart}} | (wr_ch & {3{is_evt && st_r == ST_RUN}});

genvar gi;
generate
  for (gi = 0; gi < 3; gi = gi + 1) begin : g_ch
    etc_chan u_chan (
      .clk_sys(clk_sys),
      .rst_n(rst_n_r),
      .cmp_reg(wr_ch[gi] ? avs_writedata[15:0] : ch_cmp_r[gi]),
      .load(ch_load[gi]),
      .cnt(cnt_r),
      .cnt_nxt(cnt_nxt),
      .evt_step(evt_step),
      .pwm_on(pwm_on),
      .pwm_step(pwm_step),
      .trig_hit(trig_hit),
      .restart(restart),
      .match_irq(channel_match_irq[gi]),
      .pwm_out(channel_pwm_out[gi])
    );
  end
endgenerate

endmodule // etc_timer

/* verif/etc_pin_src.sv */
`timescale 1ns/1ps
module etc_pin_src (
  input wire clk_sys,
  output logic evt_pin,
  output logic trg_pin
);
  initial begin
    evt_pin = 1'b0;
    trg_pin = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // four clocks per level
  // Shorter levels risk being lost in the pin synchroniser
  task automatic pulse(input bit which, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      if (which) trg_pin <= 1'b1;
      else evt_pin <= 1'b1;
      repeat (4) @(posedge clk_sys);
      if (which) trg_pin <= 1'b0;
      else evt_pin <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
  endtask
endmodule // etc_pin_src

/* verif/etc_timer_checker.sv */
`timescale 1ns/1ps
module etc_timer_checker (
  input wire clk_sys,
  input wire rstn,
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire event_count_input,
  input wire external_trigger_input,
  input wire period_toggle_out,
  input wire [2:0] channel_pwm_out,
  input wire period_match_irq,
  input wire [2:0] channel_match_irq
);
  reg [2:0] mode_r;
  reg run_r;
  wire req = avs_read | avs_write;
  // Mode and run snooped from accepted control writes, ports give no other view
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mode_r <= 3'h0;
      run_r <= 1'b0;
    end else if (avs_write && !avs_waitrequest && avs_address == 6'h00) begin
      mode_r <= avs_writedata[2:0];
      run_r <= avs_writedata[3];
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////
  AST_WAIT_ONE: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest not lowered after request");
  AST_WAIT_BACK: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  AST_WAIT_CAUSE: assert property (!avs_waitrequest |-> $past(req && avs_waitrequest))
    else $error("waitrequest low without request");
  AST_PIRQ_PULSE: assert property (period_match_irq |=> !period_match_irq)
    else $error("period irq longer than one cycle");
  AST_CIRQ_PULSE: assert property (channel_match_irq[0] |=> !channel_match_irq[0])
    else $error("channel irq longer than one cycle");
  AST_EVT_OUTS: assert property (mode_r == 3'h1 && $past(mode_r) == 3'h1 |->
    !period_toggle_out && channel_pwm_out == 3'h0)
    else $error("outputs driven in event mode");
  AST_PWM_PERIOD: assert property (mode_r == 3'h2 && run_r && period_match_irq |->
    period_toggle_out != $past(period_toggle_out) && channel_pwm_out == 3'h7)
    else $error("period end without toggle flip and channels high");
  // Stopping the run drops the outputs with no irq, so run must stay set
  AST_PWM_FALL: assert property (mode_r == 3'h2 && run_r && $fell(channel_pwm_out[0]) |->
    channel_match_irq[0])
    else $error("channel fall without its irq");
endmodule // etc_timer_checker
bind etc_timer etc_timer_checker etc_timer_checker_inst (
  .clk_sys(clk_sys),
  .rstn(rstn),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .event_count_input(event_count_input),
  .external_trigger_input(external_trigger_input),
  .period_toggle_out(period_toggle_out),
  .channel_pwm_out(channel_pwm_out),
  .period_match_irq(period_match_irq),
  .channel_match_irq(channel_match_irq)
);

/* verif/etc_timer_tb.sv */
`timescale 1ns/1ps
`include "etc_defs.vh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %s expected %0h seen %0h", n, e, g); end end
module etc_timer_tb;
  localparam int PER = 19;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic evt_pin;
  logic trg_pin;
  logic period_toggle_out;
  logic [2:0] channel_pwm_out;
  logic period_match_irq;
  logic [2:0] channel_match_irq;
  logic [31:0] rd;
  int fail_count = 0;
  int total_checks = 0;
  int pirq_n = 0;
  int cirq_n [3] = '{0, 0, 0};
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    pirq_n <= pirq_n + period_match_irq;
    for (int j = 0; j < 3; j++) cirq_n[j] <= cirq_n[j] + channel_match_irq[j];
  end
  etc_timer etc_timer_inst (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .event_count_input(evt_pin),
    .external_trigger_input(trg_pin),
    .period_toggle_out(period_toggle_out),
    .channel_pwm_out(channel_pwm_out),
    .period_match_irq(period_match_irq),
    .channel_match_irq(channel_match_irq)
  );
  etc_pin_src etc_pin_src_inst (
    .clk_sys(clk_sys),
    .evt_pin(evt_pin),
    .trg_pin(trg_pin)
  );
  ////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (fail_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic timeout();
    fail_count++;
    tally_and_finish();
  endtask
  // Request held until waitrequest is seen low at an edge
  task automatic bus(input bit wr, input logic [5:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'b0) break;
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (i == 20) timeout();
  endtask
  task automatic wait_irq();
    int i;
    for (i = 0; i < 400; i++) begin
      @(posedge clk_sys);
      if (period_match_irq === 1'b1) break;
    end
    if (i == 400) timeout();
  endtask
  // One full period sampled from the irq cycle onward
  task automatic measure(input int e1, input int e2);
    int h1 = 0;
    int h2 = 0;
    int h3 = 0;
    int tg = 0;
    logic t0;
    wait_irq();
    t0 = period_toggle_out;
    for (int i = 0; i <= PER; i++) begin
      h1 += channel_pwm_out[0];
      h2 += channel_pwm_out[1];
      h3 += channel_pwm_out[2];
      tg += (period_toggle_out !== t0);
      @(posedge clk_sys);
    end
    `CHK("ch1_width", e1, h1)
    `CHK("ch2_width", e2, h2)
    `CHK("ch3_width", PER + 1, h3)
    `CHK("tog_steady", 0, tg)
    `CHK("tog_flip", ~t0, period_toggle_out)
    `CHK("pirq_next", 1'b1, period_match_irq)
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_regs();
    bus(0, `ETC_OFF_CTRL, 0);
    `CHK("ctrl_rst", 32'h0, rd)
    bus(0, `ETC_OFF_PERIOD, 0);
    `CHK("per_rst", 32'hFFFF, rd)
    bus(1, `ETC_OFF_COUNT, 32'h5);
    bus(0, `ETC_OFF_COUNT, 0);
    `CHK("cnt_idle", 32'hFFFF, rd)
    bus(0, 6'h3C, 0);
    `CHK("unmapped", 32'h0, rd)
  endtask
  task automatic t_event();
    int p0;
    bus(1, `ETC_OFF_PERIOD, 32'h3);
    bus(1, `ETC_OFF_CH1, 32'h1);
    bus(1, `ETC_OFF_CH2, 32'hFFFF);
    bus(1, `ETC_OFF_CH3, 32'h2);
    p0 = pirq_n;
    // no outputs expected while counting events
    bus(1, `ETC_OFF_CTRL, {24'h0, 2'h0, `ETC_EDGE_RISE, 1'b1, `ETC_MODE_EVENT});
    bus(0, `ETC_OFF_COUNT, 0);
    `CHK("evt_start", 32'h0, rd)
    for (int k = 1; k <= 7; k++) begin
      etc_pin_src_inst.pulse(1'b0, 1);
      `CHK("evt_irqs", (k >= 3) + (k >= 7), pirq_n - p0)
    end
    bus(0, `ETC_OFF_COUNT, 0);
    `CHK("evt_clear", 32'h0, rd)
    `CHK("ch1_irqs", 2, cirq_n[0])
    `CHK("ch2_irqs", 0, cirq_n[1])
    `CHK("ch3_irqs", 2, cirq_n[2])
    // Counter left at 3, above the new period, so it must run past it
    etc_pin_src_inst.pulse(1'b0, 3);
    bus(1, `ETC_OFF_PERIOD, 32'h2);
    etc_pin_src_inst.pulse(1'b0, 4);
    bus(0, `ETC_OFF_COUNT, 0);
    `CHK("evt_count", 32'h7, rd)
    `CHK("evt_overshoot", 2, pirq_n - p0)
  endtask
  task automatic t_other();
    bus(1, `ETC_OFF_CTRL, 32'h0);
    bus(1, `ETC_OFF_CTRL, 32'hB);
    etc_pin_src_inst.pulse(1'b0, 2);
    bus(0, `ETC_OFF_COUNT, 0);
    `CHK("mode3_idle", 32'hFFFF, rd)
  endtask
  task automatic t_pwm();
    bus(1, `ETC_OFF_CTRL, 32'h0);
    bus(1, `ETC_OFF_PERIOD, PER);
    bus(1, `ETC_OFF_CH1, 32'h3);
    bus(1, `ETC_OFF_CH2, 32'hC);
    bus(1, `ETC_OFF_CH3, 32'hFFFF);
    bus(1, `ETC_OFF_CTRL, {24'h0, `ETC_EDGE_RISE, 2'h0, 1'b1, `ETC_MODE_PWM});
    bus(0, `ETC_OFF_STATUS, 0);
    `CHK("pwm_wait", 32'h1, rd)
    `CHK("wait_outs", 3'h0, channel_pwm_out)
    bus(1, `ETC_OFF_SWTRIG, 32'h1);
    repeat (3) @(posedge clk_sys);
    `CHK("sw_start", 1'b1, channel_pwm_out[2])
    measure(3, 12);
    bus(1, `ETC_OFF_CH1, 32'h6);
    measure(6, 12);
  endtask
  // Pin trigger in mid-period restarts without a period irq
  task automatic t_restart();
    int i;
    int p0;
    logic t0;
    wait_irq();
    repeat (8) @(posedge clk_sys);
    `CHK("ch1_low", 1'b0, channel_pwm_out[0])
    t0 = period_toggle_out;
    p0 = pirq_n;
    fork
      etc_pin_src_inst.pulse(1'b1, 1);
    join_none
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys);
      if (channel_pwm_out[0] === 1'b1) break;
    end
    if (i == 20) timeout();
    `CHK("rst_tog", ~t0, period_toggle_out)
    `CHK("rst_chans", 3'h7, channel_pwm_out)
    `CHK("rst_noirq", p0, pirq_n)
    repeat (10) @(posedge clk_sys);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_regs();
    t_event();
    t_other();
    t_pwm();
    t_restart();
    tally_and_finish();
  end
endmodule // etc_timer_tb
